// File: hdl/watchdog_defs.svh
// Register offsets, field positions, reset values and count limits of the watchdog.
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

`define WDG_ADDR_WIDTH       12
`define WDG_KEY_CTRL_OFFSET  12'h000

`define WDG_KEY_MSB          15
`define WDG_KEY_LSB          12
`define WDG_KEY_VALUE        4'hA
`define WDG_EN_BIT           8
`define WDG_CKSEL_BIT        6
`define WDG_STDBY_FRZ_BIT    5
`define WDG_STOP_FRZ_BIT     4
`define WDG_PR_MSB           2
`define WDG_PR_LSB           0

`define WDG_PR_RESET         3'h0
`define WDG_COUNT_START      12'hFFF
`define WDG_COUNT_END        12'h000
`define WDG_PRESC_CLEAR      8'h00
`define WDG_PRESC_STEP       8'h01
`define WDG_COUNT_STEP       12'h001
`define WDG_RDATA_ZERO       32'h0000_0000

`endif

// File: hdl/watchdog_pkg.sv
// Types shared by the watchdog design files.
package watchdog_pkg;

    // One peripheral bus request as the master drives it.
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_type;

    // Software controlled fields of the key and control register.
    typedef struct packed {
        logic       enable;
        logic       stop_clock_select;
        logic       standby_freeze;
        logic       stop_freeze;
        logic [2:0] prescaler_code;
    } ctrl_type;

    typedef enum logic [1:0] {
        WDG_IDLE,
        WDG_COUNTING,
        WDG_EXPIRED
    } wdg_state_type;

endpackage

// File: hdl/slow_osc_tick.sv
// Synchronises both low-speed oscillators and emits one enable pulse per selected rising edge.
`timescale 1ns/100ps
module slow_osc_tick (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    // Oscillator pins
    input  wire logic i_osc_internal,
    input  wire logic i_osc_external,
    // Source choice
    input  wire logic i_use_external,
    // Tick out
    output logic      o_tick
);

    logic [1:0] meta_q;
    logic [1:0] meta_d;
    logic [1:0] sync_q;
    logic [1:0] sync_d;
    logic       prev_q;
    logic       prev_d;
    logic       selected;

    // A change of source may cost or add one tick; the timeout tolerates that.
    always_comb begin
        meta_d   = {i_osc_external, i_osc_internal};
        sync_d   = meta_q;
        selected = i_use_external ? sync_q[1] : sync_q[0];
        prev_d   = selected;
        o_tick   = selected & ~prev_q;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
            prev_q <= 1'h0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

endmodule // slow_osc_tick

// File: hdl/independent_watchdog.sv
// Independent watchdog: peripheral bus register, prescaler, 12-bit down-counter and reset request.
// Function
// - Twelve-bit down-counter behind an eight-bit prescaler, fed by a low-speed oscillator.
// - Keeps counting in stop and standby unless bit 4 or bit 5 freezes it, because its clock is independent.
// - Started by the hardware option input or by software.
// - On start the counter loads 0xFFF and decrements on each prescaled tick.
// - Counter expiry while active raises the system reset request.
// - Writing key 1010 reloads the counter to its start value.
// - Key field sits at bits 15:12 and always reads back as 1010.
// - Bit 8 enables the watchdog.
// - Bit 6 picks internal or external oscillator during stop mode.
// - Standby forces the clock source, ignoring bit 6.
// - Bit 5 freezes the counter in standby.
// - Bit 4 freezes the counter in stop.
// - Bits 2:0 pick division by 2 up to 256.
// - At 40 kHz, timeout is 204.8 ms at code 0, doubling per code.
// - Debug halt freezes the counter when the debug freeze bit is set.
// - The register is a slave on the peripheral bus.
`timescale 1ns/100ps
`include "watchdog_defs.svh"
module independent_watchdog (
    // Clock and reset
    input  wire logic                     i_clock,
    input  wire logic                     i_arst_n,
    // Peripheral bus slave
    input  wire watchdog_pkg::apb_req_type i_apb,
    output logic                          o_pready,
    output logic [31:0]                   o_prdata,
    output logic                          o_pslverr,
    // Low-speed oscillators
    input  wire logic                     i_osc_internal,
    input  wire logic                     i_osc_external,
    // Option byte, power modes and debug
    input  wire logic                     i_hw_start_option,
    input  wire logic                     i_stop_mode,
    input  wire logic                     i_standby_mode,
    input  wire logic                     i_debug_halt,
    input  wire logic                     i_debug_halt_freeze_bit,
    // Reset request and status
    output logic                          o_system_reset,
    output logic [11:0]                   o_count
);

    // Prescaler wrap mask: the prescaled tick fires when the low code+1 bits are all ones.
    function automatic logic [7:0] presc_mask(input logic [2:0] code);
        presc_mask = 8'((9'h002 << code) - 9'h001);
    endfunction

    watchdog_pkg::ctrl_type      ctrl_q;
    watchdog_pkg::ctrl_type      ctrl_d;
    watchdog_pkg::wdg_state_type state_q;
    watchdog_pkg::wdg_state_type state_d;
    logic [11:0]                 count_q;
    logic [11:0]                 count_d;
    logic [7:0]                  presc_q;
    logic [7:0]                  presc_d;
    logic                        reset_q;
    logic                        reset_d;
    logic [31:0]                 prdata_q;
    logic [31:0]                 prdata_d;
    logic                        pslverr_q;
    logic                        pslverr_d;
    logic                        opt_meta_q;
    logic                        opt_q;

    logic                        mapped;
    logic                        setup_phase;
    logic                        write_access;
    logic                        key_write;
    logic                        active;
    logic                        freeze;
    logic                        use_external;
    logic                        osc_tick;
    logic                        presc_done;
    logic                        count_en;

    // Bus decode. The slave never waits, so every transfer ends in its access phase.
    always_comb begin
        mapped       = (i_apb.addr == `WDG_KEY_CTRL_OFFSET);
        setup_phase  = i_apb.sel & ~i_apb.enable;
        write_access = i_apb.sel & i_apb.enable & i_apb.write & mapped;
        key_write    = write_access
                       & (i_apb.wdata[`WDG_KEY_MSB:`WDG_KEY_LSB] == `WDG_KEY_VALUE);
        o_pready     = 1'b1;
    end

    // Register file: control fields are stored, the key field is never stored.
    always_comb begin
        ctrl_d    = ctrl_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (write_access) begin
            ctrl_d.enable            = i_apb.wdata[`WDG_EN_BIT];
            ctrl_d.stop_clock_select = i_apb.wdata[`WDG_CKSEL_BIT];
            ctrl_d.standby_freeze    = i_apb.wdata[`WDG_STDBY_FRZ_BIT];
            ctrl_d.stop_freeze       = i_apb.wdata[`WDG_STOP_FRZ_BIT];
            ctrl_d.prescaler_code    = i_apb.wdata[`WDG_PR_MSB:`WDG_PR_LSB];
        end
        if (setup_phase) begin
            prdata_d  = `WDG_RDATA_ZERO;
            pslverr_d = ~mapped;
            if (mapped && !i_apb.write) begin
                prdata_d[`WDG_KEY_MSB:`WDG_KEY_LSB] = `WDG_KEY_VALUE;
                prdata_d[`WDG_EN_BIT]               = ctrl_q.enable;
                prdata_d[`WDG_CKSEL_BIT]            = ctrl_q.stop_clock_select;
                prdata_d[`WDG_STDBY_FRZ_BIT]        = ctrl_q.standby_freeze;
                prdata_d[`WDG_STOP_FRZ_BIT]         = ctrl_q.stop_freeze;
                prdata_d[`WDG_PR_MSB:`WDG_PR_LSB]   = ctrl_q.prescaler_code;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q    <= '0;
            prdata_q  <= `WDG_RDATA_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign o_prdata  = prdata_q;
    assign o_pslverr = pslverr_q;

    // The option level comes from the option loader outside this clock domain.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            opt_meta_q <= 1'b0;
            opt_q      <= 1'b0;
        end else begin
            opt_meta_q <= i_hw_start_option;
            opt_q      <= opt_meta_q;
        end
    end

    // Standby forces the internal oscillator; stop and run follow the select bit.
    always_comb begin
        use_external = ctrl_q.stop_clock_select & ~i_standby_mode;
        active       = ctrl_q.enable | opt_q;
        freeze       = (i_stop_mode & ctrl_q.stop_freeze)
                       | (i_standby_mode & ctrl_q.standby_freeze)
                       | (i_debug_halt & i_debug_halt_freeze_bit);
        presc_done   = ((presc_q & presc_mask(ctrl_q.prescaler_code))
                        == presc_mask(ctrl_q.prescaler_code));
        count_en     = osc_tick & ~freeze;
    end

    slow_osc_tick u_tick (
        .i_clock        (i_clock),
        .i_arst_n       (i_arst_n),
        .i_osc_internal (i_osc_internal),
        .i_osc_external (i_osc_external),
        .i_use_external (use_external),
        .o_tick         (osc_tick)
    );

    // Counter and reset request. Expiry is taken on the prescaled tick seen at zero,
    // which gives 4096 ticks per full count and matches the published timeouts.
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        presc_d = presc_q;
        reset_d = reset_q;
        case (state_q)
            watchdog_pkg::WDG_IDLE: begin
                if (active) begin
                    state_d = watchdog_pkg::WDG_COUNTING;
                    count_d = `WDG_COUNT_START;
                    presc_d = `WDG_PRESC_CLEAR;
                end
            end
            watchdog_pkg::WDG_COUNTING: begin
                if (!active) begin
                    state_d = watchdog_pkg::WDG_IDLE;
                end else if (key_write) begin
                    count_d = `WDG_COUNT_START;
                    presc_d = `WDG_PRESC_CLEAR;
                end else if (count_en) begin
                    presc_d = presc_q + `WDG_PRESC_STEP;
                    if (presc_done) begin
                        if (count_q == `WDG_COUNT_END) begin
                            state_d = watchdog_pkg::WDG_EXPIRED;
                            reset_d = 1'b1;
                        end else begin
                            count_d = count_q - `WDG_COUNT_STEP;
                        end
                    end
                end
            end
            watchdog_pkg::WDG_EXPIRED: begin
                reset_d = 1'b1;
            end
            default: begin
                state_d = watchdog_pkg::WDG_IDLE;
            end
        endcase
    end

    // The request holds until the system reset it causes clears this block.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= watchdog_pkg::WDG_IDLE;
            count_q <= `WDG_COUNT_START;
            presc_q <= `WDG_PRESC_CLEAR;
            reset_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            presc_q <= presc_d;
            reset_q <= reset_d;
        end
    end

    assign o_system_reset = reset_q;
    assign o_count        = count_q;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    start_load_a: assert property (
        state_q == watchdog_pkg::WDG_IDLE && active
        |=> state_q == watchdog_pkg::WDG_COUNTING && count_q == 12'hFFF && presc_q == 8'h00)
        else $error("Start did not load the full count.");

    count_step_a: assert property (
        state_q == watchdog_pkg::WDG_COUNTING && active && !key_write && count_en
        && presc_done && count_q != 12'h000
        |=> count_q == $past(count_q) - 12'h001)
        else $error("Counter did not step down on a prescaled tick.");

    expiry_reset_a: assert property (
        state_q == watchdog_pkg::WDG_COUNTING && active && !key_write && count_en
        && presc_done && count_q == 12'h000
        |=> o_system_reset ##1 o_system_reset)
        else $error("Expiry did not raise a lasting reset request.");

    idle_no_reset_a: assert property (
        state_q != watchdog_pkg::WDG_EXPIRED |-> !o_system_reset)
        else $error("Reset request raised without expiry.");

    key_reload_a: assert property (
        state_q == watchdog_pkg::WDG_COUNTING && active && key_write
        |=> count_q == 12'hFFF && presc_q == 8'h00 && !o_system_reset)
        else $error("Key write did not reload the counter.");

    key_readback_a: assert property (
        setup_phase && mapped && !i_apb.write
        |=> o_prdata[15:12] == 4'hA && o_prdata[8] == $past(ctrl_q.enable) && !o_pslverr)
        else $error("Key field did not read back as the fixed pattern.");

    enable_write_a: assert property (
        write_access |=> ctrl_q.enable == $past(i_apb.wdata[8])
        && ctrl_q.prescaler_code == $past(i_apb.wdata[2:0]))
        else $error("Control write was not stored.");

    freeze_hold_a: assert property (
        state_q == watchdog_pkg::WDG_COUNTING && active && !key_write && freeze
        |=> $stable(count_q) && $stable(presc_q))
        else $error("Counter moved while frozen.");

    standby_source_a: assert property (
        i_standby_mode |-> !use_external)
        else $error("Standby did not force the internal oscillator.");

    unmapped_error_a: assert property (
        setup_phase && !mapped |=> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("Unmapped access was not refused.");

endmodule // independent_watchdog

// File: tb/host_model.sv
// Host side model: peripheral bus master transfers and the two low-speed oscillators.
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic                 i_clock,
    // Oscillator control
    input  wire logic                 i_ext_run,
    // Peripheral bus answer
    input  wire logic                 i_pready,
    input  wire logic [31:0]          i_prdata,
    input  wire logic                 i_pslverr,
    // Peripheral bus request
    output watchdog_pkg::apb_req_type o_apb,
    // Oscillators
    output logic                      o_osc_internal,
    output logic                      o_osc_external
);
    logic [2:0] phase = 3'h0;

    initial o_apb = '0;

    // Six clocks a period keeps each phase three clocks long, three times the one clock the sampler takes.
    always @(negedge i_clock) begin
        phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
    end
    assign o_osc_internal = (phase < 3'h3);
    // A stopped crystal stands low; the running one lags the internal one by a clock.
    assign o_osc_external = i_ext_run && (phase != 3'h0) && (phase < 3'h4);

    // Released lines carry the inverse of the last request so stale values never match.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(negedge i_clock);
        o_apb <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
        @(negedge i_clock);
        o_apb.enable <= 1'b1;
        do @(posedge i_clock); while (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        @(negedge i_clock);
        o_apb <= '{sel: 1'b0, enable: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask
endmodule // host_model

// File: tb/testbench.sv
// Self-checking bench for the watchdog register, prescaler, freezes and expiry.
`timescale 1ns/100ps
module testbench;
    logic                      i_clock = 1'b0;
    logic                      i_arst_n = 1'b0;
    logic                      hw_start = 1'b0;
    logic                      ext_run = 1'b1;
    logic [3:0]                mode = 4'h0;
    watchdog_pkg::apb_req_type apb;
    logic                      pready;
    logic                      pslverr;
    logic                      sys_rst;
    logic                      osc_int;
    logic                      osc_ext;
    logic [31:0]               prdata;
    logic [31:0]               rd;
    logic                      err;
    logic [11:0]               count;
    logic [11:0]               v;
    int                        mismatches = 0;
    int                        checked = 0;
    int                        n;
    // Freeze table: control word, mode {freeze bit, halt, standby, stop}, counter held.
    logic [15:0]               fz_ctrl [7] = '{16'hA130, 16'hA130, 16'hA100, 16'hA100,
                                               16'hA100, 16'hA140, 16'hA140};
    logic [3:0]                fz_mode [7] = '{4'h1, 4'h2, 4'h1, 4'hC, 4'h4, 4'h1, 4'h2};
    logic                      fz_held [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    always #2 i_clock = ~i_clock;

    host_model host_u (
        .i_clock        (i_clock),
        .i_ext_run      (ext_run),
        .i_pready       (pready),
        .i_prdata       (prdata),
        .i_pslverr      (pslverr),
        .o_apb          (apb),
        .o_osc_internal (osc_int),
        .o_osc_external (osc_ext)
    );

    independent_watchdog dut_u (
        .i_clock                 (i_clock),
        .i_arst_n                (i_arst_n),
        .i_apb                   (apb),
        .o_pready                (pready),
        .o_prdata                (prdata),
        .o_pslverr               (pslverr),
        .i_osc_internal          (osc_int),
        .i_osc_external          (osc_ext),
        .i_hw_start_option       (hw_start),
        .i_stop_mode             (mode[0]),
        .i_standby_mode          (mode[1]),
        .i_debug_halt            (mode[2]),
        .i_debug_halt_freeze_bit (mode[3]),
        .o_system_reset          (sys_rst),
        .o_count                 (count)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rdr(input logic [11:0] a);
        host_u.xfer(1'b0, a, 32'h0000_0000, rd, err);
    endtask

    // Clocks until the counter moves, so a second call measures one whole step.
    task automatic gap(output int c);
        logic [11:0] s;
        s = count;
        c = 0;
        while (count === s && c < 8000) begin
            @(negedge i_clock);
            c++;
        end
    endtask

    task automatic stop_test;
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // The tests need about 76,000 clocks, so this limit leaves a margin and stays near 90,000.
    initial begin
        #360us;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (2) @(negedge i_clock);
        i_arst_n = 1'b1;
        check(32'(count), 32'h0000_0FFF);
        check(32'(pready), 32'h0000_0001);
        rdr(12'h000);
        check(rd, 32'h0000_A000);
        wr(12'h000, 32'hFFFF_0F77);
        rdr(12'h000);
        check(rd, 32'h0000_A177);
        wr(12'h004, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        rdr(12'h004);
        check({rd[31:1], err}, 32'h0000_0001);
        rdr(12'h000);
        check(rd, 32'h0000_A177);
        for (int k = 0; k < 8; k++) begin
            wr(12'h000, 32'h0000_A100 | k);
            gap(n);
            gap(n);
            check(32'(n), 32'(12 << k));
        end
        wr(12'h000, 32'h0000_0000);
        v = count;
        repeat (100) @(negedge i_clock);
        check(32'(count), 32'(v));
        wr(12'h000, 32'h0000_0107);
        // The start load lands one edge after the enable bit is stored.
        @(negedge i_clock);
        check(32'(count), 32'h0000_0FFF);
        ext_run = 1'b0;
        for (int k = 0; k < 7; k++) begin
            wr(12'h000, {16'h0000, fz_ctrl[k]});
            mode = fz_mode[k];
            @(negedge i_clock);
            v = count;
            repeat (60) @(negedge i_clock);
            check(32'(count === v), 32'(fz_held[k]));
        end
        mode = 4'h0;
        ext_run = 1'b1;
        wr(12'h000, 32'h0000_A100);
        repeat (20000) @(negedge i_clock);
        wr(12'h000, 32'h0000_A100);
        check(32'(count), 32'h0000_0FFF);
        check(32'(sys_rst), 32'h0000_0000);
        n = 0;
        while (sys_rst !== 1'b1 && n < 60000) begin
            @(negedge i_clock);
            n++;
        end
        check(32'(n >= 49128 && n <= 49164), 32'h0000_0001);
        wr(12'h000, 32'h0000_A100);
        check(32'(sys_rst), 32'h0000_0001);
        i_arst_n = 1'b0;
        hw_start = 1'b1;
        repeat (2) @(negedge i_clock);
        i_arst_n = 1'b1;
        check({31'h0, sys_rst}, 32'h0000_0000);
        repeat (200) @(negedge i_clock);
        check(32'(count < 12'hFFF), 32'h0000_0001);
        stop_test();
    end
endmodule // testbench
